// File: design/esc_spi_slave.sv
`default_nettype none

module esc_spi_slave
  import esc_pkg::*;
(
  input  wire logic        clk,          // System clock.
  input  wire logic        rst,          // Asynchronous reset, active high.
  input  wire logic        sck,          // Serial clock from the host.
  input  wire logic        ssN,          // Slave select, active low.
  input  wire logic        mosi,         // Serial data from the host.
  input  wire logic        wireModePin,  // Wire-count select strap.
  input  wire logic [13:0] regRdData,    // Read data, sampled at the clock edge that ends regRead.
  output logic             miso,         // Serial data to the host.
  output logic             misoOe,       // Drive enable for miso.
  output logic             regWrite,     // One-cycle write strobe.
  output logic             regRead,      // One-cycle read strobe.
  output logic [13:0]      regAddr,      // Register address.
  output logic [13:0]      regWrData,    // Register write data.
  output logic             errorBit,     // Transfer error flag.
  output logic             fourWire,     // Latched wire mode, high for 4-wire.
  output logic             softReset,    // One-cycle software reset pulse.
  output logic             spiRegsReset, // Interface registers reset with it.
  output logic             trimReload    // Trim store reload pulse: one cycle on soft reset, held high through reset.
);

  esc_core_t core;
  esc_core_t next_core;
  esc_rx_t   rx;
  esc_rx_t   next_rx;
  esc_tx_t   tx;
  esc_tx_t   next_tx;
  logic [4:0] rxCnt;
  logic [4:0] next_rxCnt;
  logic       frameIdle;

  // Serial logic only clocks inside a frame, so the frame's own select ends it.
  assign frameIdle = rst | ssN;

  function automatic logic [15:0] mkResp(input logic [13:0] data, input logic err);
    mkResp = {data, err, ^{data, err}};
  endfunction : mkResp

  // Edge counter of the current frame; it restarts with every select.
  always_comb
  begin
    next_rxCnt = (rxCnt == CNT_OVER) ? CNT_OVER : 5'(rxCnt + 5'h01);
  end

  // The host owns both the serial clock and the select; nothing here makes them.
  always_ff @(negedge sck or posedge frameIdle)
  begin
    if (frameIdle)
      rxCnt <= CNT_RESET;
    else
      rxCnt <= next_rxCnt;
  end

  // The shift word and the count survive the select edge so that the system
  // side can read them after the frame; they are quiet until the next frame.
  always_comb
  begin
    next_rx       = rx;
    next_rx.shift = {rx.shift[14:0], mosi};
    next_rx.cnt   = next_rxCnt;
    if (rxCnt == CNT_RESET)
      next_rx.frameTog = ~rx.frameTog;
  end

  always_ff @(negedge sck or posedge rst)
  begin
    if (rst)
      rx <= '{shift: WORD_RESET, cnt: CNT_RESET, frameTog: 1'b0};
    else
      rx <= next_rx;
  end

  // The answer word changes only a few system cycles after select rises, well
  // inside the select high time, so it is steady for a whole frame.
  always_comb
  begin
    next_tx        = tx;
    next_tx.misoOe = 1'b1;
    next_tx.miso   = 1'b0;
    if (tx.cnt < CNT_FULL)
    begin
      next_tx.miso = core.resp[4'hF - tx.cnt[3:0]];
      next_tx.cnt  = 5'(tx.cnt + 5'h01);
    end
  end

  always_ff @(posedge sck or posedge frameIdle)
  begin
    if (frameIdle)
      tx <= '{cnt: CNT_RESET, miso: 1'b0, misoOe: 1'b0};
    else
      tx <= next_tx;
  end

  always_comb
  begin
    next_core              = core;
    next_core.ssSync1      = ssN;
    next_core.ssSync2      = core.ssSync1;
    next_core.ssPrev       = core.ssSync2;
    next_core.togSync1     = rx.frameTog;
    next_core.togSync2     = core.togSync1;
    next_core.wmSync1      = wireModePin;
    next_core.wmSync2      = core.wmSync1;
    next_core.req.write    = 1'b0;
    next_core.req.read     = 1'b0;
    next_core.ctrl.softReset  = 1'b0;
    next_core.ctrl.trimReload = 1'b0;
    // The strap synchroniser is cleared by reset, so after power-up the mode is
    // caught again on each of three edges and the last catch is a settled one.
    if (core.latchWire != 3'h0)
    begin
      next_core.latchWire = core.latchWire >> 1;
      next_core.fourWire  = core.wmSync2;
    end
    case (core.state)
      ESC_IDLE:
      begin
        if (core.ssSync2 && !core.ssPrev)
        begin
          next_core.frameWord = rx.shift;
          next_core.frameCnt  = rx.cnt;
          next_core.frameSeen = core.togSync2 != core.togSeen;
          next_core.togSeen   = core.togSync2;
          next_core.state     = ESC_DECODE;
        end
      end
      ESC_DECODE:
      begin
        next_core.state = ESC_IDLE;
        if (!core.frameSeen || core.frameCnt != CNT_FULL || ^core.frameWord)
        begin
          next_core.errorBit  = 1'b1;
          next_core.pendWrite = 1'b0;
          next_core.resp      = mkResp(DATA_RESET, 1'b1);
        end
        else if (core.pendWrite)
        begin
          next_core.pendWrite = 1'b0;
          if (core.pendAddr == ADDR_SOFT_RESET)
          begin
            next_core.ctrl.softReset    = 1'b1;
            next_core.ctrl.trimReload   = 1'b1;
            next_core.ctrl.spiRegsReset = core.frameWord[RES_SEL_POS];
            next_core.latchWire         = LATCH_SOFT;
            if (core.frameWord[RES_SEL_POS])
            begin
              next_core.errorBit = 1'b0;
              next_core.resp     = mkResp(DATA_RESET, 1'b0);
            end
            else
              next_core.resp = mkResp(DATA_RESET, core.errorBit);
          end
          else
          begin
            next_core.req.write = 1'b1;
            next_core.req.addr  = core.pendAddr;
            next_core.req.data  = core.frameWord[15:2];
            next_core.resp      = mkResp(core.frameWord[15:2], core.errorBit);
          end
        end
        else if (core.frameWord[RW_POS])
        begin
          if (core.frameWord[14:1] == ADDR_CLEAR_ERROR)
          begin
            next_core.errorBit = 1'b0;
            next_core.resp     = mkResp(DATA_RESET, 1'b0);
          end
          else if (core.frameWord[14:1] == ADDR_SOFT_RESET || core.frameWord[14:1] == ADDR_NOP)
          begin
            next_core.errorBit = 1'b1;
            next_core.resp     = mkResp(DATA_RESET, 1'b1);
          end
          else
          begin
            next_core.req.read = 1'b1;
            next_core.req.addr = core.frameWord[14:1];
            next_core.state    = ESC_FETCH;
          end
        end
        else if (core.frameWord[14:1] == ADDR_NOP)
          next_core.resp = mkResp(DATA_RESET, core.errorBit);
        else if (core.frameWord[14:1] == ADDR_CLEAR_ERROR)
        begin
          next_core.errorBit = 1'b1;
          next_core.resp     = mkResp(DATA_RESET, 1'b1);
        end
        else
        begin
          next_core.pendWrite = 1'b1;
          next_core.pendAddr  = core.frameWord[14:1];
          next_core.resp      = mkResp(DATA_RESET, core.errorBit);
        end
      end
      ESC_FETCH:
      begin
        next_core.resp  = mkResp(regRdData, core.errorBit);
        next_core.state = ESC_IDLE;
      end
      default:
        next_core.state = ESC_IDLE;
    endcase
  end

  // After reset the trim store reloads once and the wire mode is caught from
  // the synchronised strap, never from the pin inside the reset branch.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      core                   <= '0;
      core.state             <= ESC_IDLE;
      core.ssSync1           <= 1'b1;
      core.ssSync2           <= 1'b1;
      core.ssPrev            <= 1'b1;
      core.latchWire         <= LATCH_POWER_UP;
      core.ctrl.trimReload   <= 1'b1;
    end
    else
      core <= next_core;
  end

  assign miso         = tx.miso;
  assign misoOe       = tx.misoOe;
  assign regWrite     = core.req.write;
  assign regRead      = core.req.read;
  assign regAddr      = core.req.addr;
  assign regWrData    = core.req.data;
  assign errorBit     = core.errorBit;
  assign fourWire     = core.fourWire;
  assign softReset    = core.ctrl.softReset;
  assign spiRegsReset = core.ctrl.spiRegsReset;
  assign trimReload   = core.ctrl.trimReload;

endmodule : esc_spi_slave

`default_nettype wire

// File: design/esc_pkg.sv
`default_nettype none

package esc_pkg;

  localparam int          FRAME_BITS       = 16;
  localparam int          DATA_BITS        = 14;
  localparam int          RW_POS           = 15;
  localparam int          ERROR_POS        = 1;
  localparam int          PARITY_POS       = 0;
  localparam int          RES_SEL_POS      = 2;
  localparam logic [13:0] ADDR_NOP         = 14'h0000;
  localparam logic [13:0] ADDR_SOFT_RESET  = 14'h3C00;
  localparam logic [13:0] ADDR_CLEAR_ERROR = 14'h3380;
  localparam logic [4:0]  CNT_RESET        = 5'h00;
  localparam logic [4:0]  CNT_FULL         = 5'h10;
  localparam logic [4:0]  CNT_OVER         = 5'h11;
  localparam logic [15:0] WORD_RESET       = 16'h0000;
  localparam logic [2:0]  LATCH_POWER_UP   = 3'h4;
  localparam logic [2:0]  LATCH_SOFT       = 3'h1;
  localparam logic [13:0] DATA_RESET       = 14'h0000;

  typedef enum logic [1:0] {
    ESC_IDLE   = 2'b00,
    ESC_DECODE = 2'b01,
    ESC_FETCH  = 2'b10
  } esc_state_t;

  // Register access request handed to the register file.
  typedef struct packed {
    logic        write;
    logic        read;
    logic [13:0] addr;
    logic [13:0] data;
  } esc_reg_req_t;

  // Control strobes and the held spiRegsReset level handed to the rest of the device.
  typedef struct packed {
    logic softReset;
    logic spiRegsReset;
    logic trimReload;
  } esc_ctrl_t;

  // Everything the system-clock side keeps.
  typedef struct packed {
    esc_state_t   state;
    logic         ssSync1;
    logic         ssSync2;
    logic         ssPrev;
    logic         togSync1;
    logic         togSync2;
    logic         togSeen;
    logic         wmSync1;
    logic         wmSync2;
    logic [2:0]   latchWire;
    logic         fourWire;
    logic         errorBit;
    logic         pendWrite;
    logic [13:0]  pendAddr;
    logic [15:0]  resp;
    logic [15:0]  frameWord;
    logic [4:0]   frameCnt;
    logic         frameSeen;
    esc_reg_req_t req;
    esc_ctrl_t    ctrl;
  } esc_core_t;

  // Receive side, falling serial clock edge, kept across frames.
  typedef struct packed {
    logic [15:0] shift;
    logic [4:0]  cnt;
    logic        frameTog;
  } esc_rx_t;

  // Transmit side, rising serial clock edge, cleared between frames.
  typedef struct packed {
    logic [4:0] cnt;
    logic       miso;
    logic       misoOe;
  } esc_tx_t;

endpackage : esc_pkg

`default_nettype wire

// File: testbench/esc_spi_slave_monitor.sv
`default_nettype none

module esc_spi_monitor
  import esc_pkg::*;
(
  input wire logic        clk,       // System clock.
  input wire logic        rst,       // Reset.
  input wire logic        ssN,       // Select.
  input wire logic        misoOe,    // Drive enable.
  input wire logic        regWrite,  // Write strobe.
  input wire logic        regRead,   // Read strobe.
  input wire logic [13:0] regAddr,   // Address.
  input wire logic        errorBit,  // Error flag.
  input wire logic        fourWire,  // Wire mode.
  input wire logic        softReset, // Reset pulse.
  input wire logic        trimReload // Reload pulse.
);
  logic [3:0] up;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // The strap capture right after reset is a legal change, so mode checks wait four edges.
  always_ff @(posedge clk or posedge rst)
    if (rst)
      up <= 4'h0;
    else
      up <= {up[2:0], 1'b1};

  property p_idle_off; ssN |-> !misoOe; endproperty
  a_idle_off: assert property (p_idle_off) else $error("miso enabled while deselected");
  property p_wr_one; regWrite |=> !regWrite; endproperty
  a_wr_one: assert property (p_wr_one) else $error("write strobe too long");
  property p_rd_one; regRead |=> !regRead && !regWrite; endproperty
  a_rd_one: assert property (p_rd_one) else $error("read strobe too long");
  property p_req_gap; (regRead || regWrite) |-> ssN; endproperty
  a_req_gap: assert property (p_req_gap) else $error("request inside a frame");
  property p_no_bad_wr; regWrite |-> regAddr != ADDR_CLEAR_ERROR; endproperty
  a_no_bad_wr: assert property (p_no_bad_wr) else $error("write to clear address passed");
  property p_err_hold; errorBit && !ssN |=> errorBit; endproperty
  a_err_hold: assert property (p_err_hold) else $error("error flag dropped in a frame");
  property p_sr_trim; softReset |-> trimReload ##1 !softReset; endproperty
  a_sr_trim: assert property (p_sr_trim) else $error("reset pulse without reload");
  property p_wire_hold; up[3] && $changed(fourWire) |-> $past(softReset) || $past(softReset, 2); endproperty
  a_wire_hold: assert property (p_wire_hold) else $error("wire mode changed alone");
endmodule : esc_spi_monitor

bind esc_spi_slave esc_spi_monitor mon (.clk(clk), .rst(rst), .ssN(ssN), .misoOe(misoOe), .regWrite(regWrite),
  .regRead(regRead), .regAddr(regAddr), .errorBit(errorBit), .fourWire(fourWire), .softReset(softReset),
  .trimReload(trimReload));

`default_nettype wire

// File: testbench/esc_host_model.sv
`default_nettype none

module esc_host_model (
  output logic     sck,  // Serial clock.
  output logic     ssN,  // Select, active low.
  output logic     mosi, // Data to device.
  input wire logic miso  // Data from device.
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    sck = 1'b0;
    ssN = 1'b1;
    mosi = 1'b0;
  end

  // The clock stands still between frames; mosi has no pull, so it is inverted once released.
  task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
    rx = 16'h0000;
    ssN = 1'b0;
    #20;
    for (int i = 0; i < n; i++)
    begin
      mosi = tx[15 - (i % 16)];
      sck = 1'b1;
      #7.5;
      rx = {rx[14:0], miso};
      sck = 1'b0;
      #7.5;
    end
    #7.5;
    ssN = 1'b1;
    mosi = ~mosi;
    #120;
  endtask : xfer
endmodule : esc_host_model

`default_nettype wire

// File: testbench/encoder_spi_command_slave_tb_top.sv
`default_nettype none

module encoder_spi_command_slave_tb_top;
  import esc_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk, rst, sck, ssN, mosi, wireModePin, miso, misoOe, regWrite, regRead;
  logic        errorBit, fourWire, softReset, spiRegsReset, trimReload;
  logic [13:0] regRdData, regAddr, regWrData;
  logic [15:0] rx;
  int          miscompares = 0;
  int          comparisons = 0;
  int          nRd = 0;
  int          nWr = 0;
  int          nSr = 0;

  esc_spi_slave uut (.clk(clk), .rst(rst), .sck(sck), .ssN(ssN), .mosi(mosi), .wireModePin(wireModePin),
    .regRdData(regRdData), .miso(miso), .misoOe(misoOe), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWrData(regWrData), .errorBit(errorBit), .fourWire(fourWire),
    .softReset(softReset), .spiRegsReset(spiRegsReset), .trimReload(trimReload));
  esc_host_model host (.sck(sck), .ssN(ssN), .mosi(mosi), .miso(miso));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Register file stand-in: read data follows the address off the edge, so it
  // stands at the edge after the read strobe.
  always @(negedge clk)
    regRdData <= regAddr ^ 14'h2A5A;

  always @(posedge clk)
  begin
    if (regRead) nRd++;
    if (regWrite) nWr++;
    if (softReset) nSr++;
  end

  function automatic logic [15:0] par(input logic [14:0] v);
    return {v, ^v};
  endfunction : par

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic print_verdict;
    $display("Comparisons %0d, miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict

  task automatic t_read;
    int old = nRd;
    host.xfer(par({1'b1, 14'h1234}), 16, rx);
    chk("read strobes", nRd, old + 1);
    chk("read address", regAddr, 14'h1234);
    host.xfer(par({1'b1, 14'h0ABC}), 16, rx);
    chk("read data", rx, par({14'h1234 ^ 14'h2A5A, 1'b0}));
    chk("second address", regAddr, 14'h0ABC);
    host.xfer(16'h0000, 16, rx);
    chk("second data", rx, par({14'h0ABC ^ 14'h2A5A, 1'b0}));
  endtask : t_read

  task automatic t_write;
    int old = nWr;
    host.xfer(par({1'b0, 14'h0155}), 16, rx);
    host.xfer(par({14'h2AAA, 1'b1}), 16, rx);
    chk("write strobes", nWr, old + 1);
    chk("write address", regAddr, 14'h0155);
    chk("write data", regWrData, 14'h2AAA);
    host.xfer(16'h0000, 16, rx);
    chk("write echo", rx, par({14'h2AAA, 1'b0}));
  endtask : t_write

  // Bad parity, short, long, write to the clear address, read of the idle address.
  task automatic t_err;
    logic [15:0] bad [5] = '{par({1'b1, 14'h0100}) ^ 16'h0001, par({1'b1, 14'h0100}), par({1'b1, 14'h0100}),
                            par({1'b0, ADDR_CLEAR_ERROR}), par({1'b1, ADDR_NOP})};
    int len [5] = '{16, 8, 17, 16, 16};
    for (int i = 0; i < 5; i++)
    begin
      host.xfer(bad[i], len[i], rx);
      chk("error raised", errorBit, 1'b1);
      host.xfer(16'h0000, 16, rx);
      chk("error held", errorBit, 1'b1);
      host.xfer(par({1'b1, ADDR_CLEAR_ERROR}), 16, rx);
      chk("flagged answer", rx, 16'h0003);
      chk("error cleared", errorBit, 1'b0);
      host.xfer(16'h0000, 16, rx);
      chk("clear answer", rx, 16'h0000);
    end
  endtask : t_err

  task automatic t_soft;
    int old = nSr;
    @(posedge clk);
    #1 wireModePin = 1'b0;
    host.xfer(16'h0001, 16, rx);
    chk("wire mode held", fourWire, 1'b1);
    host.xfer(par({1'b0, ADDR_SOFT_RESET}), 16, rx);
    host.xfer(par({14'h0001, 1'b0}), 16, rx);
    chk("reset pulses", nSr, old + 1);
    chk("register reset select", spiRegsReset, 1'b1);
    chk("error after reset", errorBit, 1'b0);
    chk("wire mode relatched", fourWire, 1'b0);
    host.xfer(par({1'b1, 14'h0100}), 16, rx);
    chk("answer after reset", rx, 16'h0000);
    host.xfer(16'h0000, 16, rx);
    chk("read after reset", rx, par({14'h0100 ^ 14'h2A5A, 1'b0}));
  endtask : t_soft

  // In 3-wire mode a raised flag is also recovered by an external reset.
  task automatic t_ext;
    host.xfer(par({1'b1, ADDR_NOP}), 16, rx);
    chk("error before reset", errorBit, 1'b1);
    @(posedge clk);
    #1 rst = 1'b1;
    repeat (3) @(posedge clk);
    chk("reload in mid reset", trimReload, 1'b1);
    #1 rst = 1'b0;
    repeat (4) @(posedge clk);
    chk("error after external reset", errorBit, 1'b0);
    chk("3-wire mode after reset", fourWire, 1'b0);
    host.xfer(16'h0000, 16, rx);
    chk("answer after external reset", rx, 16'h0000);
  endtask : t_ext

  initial
  begin
    rst = 1'b1;
    wireModePin = 1'b1;
    repeat (10) @(posedge clk);
    chk("reload in reset", trimReload, 1'b1);
    #1 rst = 1'b0;
    repeat (4) @(posedge clk);
    chk("wire mode latched", fourWire, 1'b1);
    chk("error after power-up", errorBit, 1'b0);
    t_read();
    t_write();
    t_err();
    t_soft();
    t_ext();
    print_verdict();
  end

  initial
  begin
    #100us;
    miscompares++;
    $display("[ERR] run length expected end seen hang");
    print_verdict();
  end
endmodule : encoder_spi_command_slave_tb_top

`default_nettype wire
